// ==== common/rpc_cfg.svh ====
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define RPC_CLK_PERIOD_NS 100
`define RPC_OSC_STABLE_NS 10000
`define RPC_OSC_STABLE_CYC \
   ((`RPC_OSC_STABLE_NS + `RPC_CLK_PERIOD_NS - 1) / `RPC_CLK_PERIOD_NS)
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RPC_ADDR_CTRL 8'h00
`define RPC_ADDR_PORT7 8'h04
`define RPC_ADDR_GP_OUT 8'h08
`define RPC_ADDR_GP_DIR 8'h0C
`define RPC_ADDR_STATUS 8'h10
`define RPC_ADDR_INT_STAT 8'h14
`define RPC_ADDR_INT_MASK 8'h18
`define RPC_ADDR_TEST 8'h1C
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RPC_CTRL_FLOAT_EN 0
`define RPC_CTRL_SPD_EN 1
`define RPC_CTRL_TX_SEL 2
`define RPC_CTRL_RX_SEL 3
`define RPC_CTRL_EXT_EN 4
`define RPC_CTRL_RST 5'h00
`define RPC_GP_RST 4'h0
`define RPC_TEST_DRV_LSB 4
`define RPC_TEST_IN_LSB 8
`define RPC_EVT_EXT 0
`define RPC_EVT_FLT 1
`define RPC_EVT_RDY 2
`define RPC_PIN_TX 0
`define RPC_PIN_RX 1
`define RPC_PIN_EXT 2
`define RPC_PIN_FLT 3
`define RPC_SPI_MISO 2
`define RPC_HSEL_SPI 2'h2
`endif

// ==== common/rpc_pkg.sv ====
package rpc_pkg;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_PWRDN = 2'b01,
      ST_RSTWAIT = 2'b10,
      ST_SOFTPD = 2'b11
   } rpc_state_e;
   typedef logic [3:0] rpc_nib_t;
endpackage

// ==== common/rpc_regs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rpc_regs_if;
   import rpc_pkg::*;
   logic [4:0] ctrl;
   logic port7_irq;
   rpc_nib_t gp_out;
   rpc_nib_t gp_dir;
   rpc_nib_t test_out;
   rpc_nib_t test_drv;
   logic [2:0] evt;
   logic [15:0] status;
   rpc_nib_t test_in;
   logic test_en;
   logic core_rst;
   modport regs(output ctrl, port7_irq, gp_out, gp_dir, test_out, test_drv,
                input evt, status, test_in, test_en, core_rst);
   modport core(input ctrl, port7_irq, gp_out, gp_dir, test_out, test_drv,
                output evt, status, test_in, test_en, core_rst);
endinterface
`default_nettype wire

// ==== hdl/rpc_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpc_sync3 #(
   parameter int W = 4
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   import rpc_pkg::*;
   logic [W-1:0] s1, s2, s3, next_q;
   // Accept a bit once the second and third stages agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         next_q[i] = (s2[i] == s3[i]) ? s3[i] : q_o[i];
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q_o <= '0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         q_o <= next_q;
      end
   end
endmodule // rpc_sync3
`default_nettype wire

// ==== hdl/rpc_apb_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"
module rpc_apb_regs
   import rpc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic intr_o,
   rpc_regs_if.regs rf
);
   logic [4:0] ctrl, next_ctrl;
   logic port7, next_port7;
   rpc_nib_t gout, gdir, tout, tdrv, next_gout, next_gdir, next_tout, next_tdrv;
   logic [2:0] istat, imask, next_istat, next_imask;
   logic [31:0] next_prdata, rd;
   logic next_pready, next_err, next_intr, wr, hit;

   assign rf.ctrl = ctrl;
   assign rf.port7_irq = port7;
   assign rf.gp_out = gout;
   assign rf.gp_dir = gdir;
   assign rf.test_out = tout;
   assign rf.test_drv = tdrv;

   // APB decode, write effects, sticky events and read mux
   always_comb begin
      hit = (paddr_i[1:0] == 2'h0) && (paddr_i[7:5] == 3'h0);
      wr = psel_i && penable_i && pready_o && pwrite_i && hit;
      next_pready = psel_i && penable_i && !pready_o;
      next_err = next_pready && !hit;
      next_ctrl = ctrl;
      next_port7 = port7;
      next_gout = gout;
      next_gdir = gdir;
      next_tout = tout;
      next_tdrv = tdrv;
      next_imask = imask;
      next_istat = istat;
      if (wr) begin
         unique case (paddr_i)
            `RPC_ADDR_CTRL: next_ctrl = pwdata_i[4:0];
            `RPC_ADDR_PORT7: next_port7 = pwdata_i[0]; // [RULE4]
            `RPC_ADDR_GP_OUT: next_gout = pwdata_i[3:0];
            `RPC_ADDR_GP_DIR: next_gdir = pwdata_i[3:0];
            `RPC_ADDR_INT_STAT: next_istat = istat & ~pwdata_i[2:0];
            `RPC_ADDR_INT_MASK: next_imask = pwdata_i[2:0];
            `RPC_ADDR_TEST: begin
               next_tout = pwdata_i[3:0];
               next_tdrv = pwdata_i[`RPC_TEST_DRV_LSB+:4];
            end
            default: ;
         endcase
      end
      next_istat = next_istat | rf.evt; // Set wins over clear
      if (!rf.test_en) begin
         next_tout = '0; // [RULE11]
         next_tdrv = '0; // [RULE11]
      end
      next_intr = |(next_istat & next_imask);
      unique case (paddr_i)
         `RPC_ADDR_CTRL: rd = {27'h0, ctrl};
         `RPC_ADDR_PORT7: rd = {31'h0, port7};
         `RPC_ADDR_GP_OUT: rd = {28'h0, gout};
         `RPC_ADDR_GP_DIR: rd = {28'h0, gdir};
         `RPC_ADDR_STATUS: rd = {16'h0, rf.status};
         `RPC_ADDR_INT_STAT: rd = {29'h0, istat};
         `RPC_ADDR_INT_MASK: rd = {29'h0, imask};
         `RPC_ADDR_TEST: rd = {20'h0, rf.test_in, tdrv, tout};
         default: rd = 32'h0000_0000;
      endcase
      next_prdata = next_pready ? rd : prdata_o;
   end

   // Bus answer runs on the system reset only; the rest also on reset phase
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= next_pready;
         pslverr_o <= next_err;
         prdata_o <= next_prdata;
      end
      if (srst_i || rf.core_rst) begin
         ctrl <= `RPC_CTRL_RST;
         port7 <= 1'b0;
         gout <= `RPC_GP_RST;
         gdir <= `RPC_GP_RST;
         tout <= '0;
         tdrv <= '0;
         istat <= 3'h0;
         imask <= 3'h0;
         intr_o <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         port7 <= next_port7;
         gout <= next_gout;
         gdir <= next_gdir;
         tout <= next_tout;
         tdrv <= next_tdrv;
         istat <= next_istat;
         imask <= next_imask;
         intr_o <= next_intr;
      end
   end
endmodule // rpc_apb_regs
`default_nettype wire

// ==== hdl/rpc_pin_ctrl.sv ====
// What this block does
// RULE1: Pin high stops current sources and oscillator, isolates input pads.
// RULE2: Rising edge of reset/power-down pin starts the internal reset phase.
// RULE3: Reset indicator output stays low throughout the reset state.
// RULE4: Host interrupt output follows bit 0 of internal port 7.
// RULE5: Float pin places selected host interface outputs in high impedance.
// RULE6: Float pin enters power-down keeping internal state, no reset.
// RULE7: External interrupt pin is GPIO or controller interrupt source.
// RULE8: Setting picks GPIO or secondary serial transmit on first aux pin.
// RULE9: Setting picks GPIO or secondary serial receive on second aux pin.
// RULE10: Test mode turns host SPI pins into bidirectional test signals.
// RULE11: Test enable high allows test mode; low clears and blocks it.
// RULE12: Two select lines choose the host interface; board holds them.
// RULE13: Reset held until oscillator stable, then released, indicator high.
// RULE14: During power-down, host interrupt and interface outputs stay inactive.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"
module rpc_pin_ctrl
   import rpc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic intr_o,
   input wire logic reset_powerdown_in_i,
   input wire logic test_mode_enable_in_i,
   input wire logic host_select_line_a_i,
   input wire logic host_select_line_b_i,
   output logic reset_indicator_out_o,
   output logic core_reset_o,
   output logic osc_enable_o,
   output logic current_src_en_o,
   output logic pad_isolate_o,
   output logic host_irq_o,
   output logic host_drive_en_o,
   output logic [1:0] host_sel_o,
   input wire logic [3:0] spi_pin_in_i,
   output logic [3:0] spi_pin_out_o,
   output logic [3:0] spi_pin_oe_n_o,
   output logic [3:0] spi_core_in_o,
   input wire logic spi_core_miso_i,
   input wire logic [3:0] gp_pin_in_i,
   output logic [3:0] gp_pin_out_o,
   output logic [3:0] gp_pin_oe_n_o,
   input wire logic aux_uart_tx_i,
   output logic aux_uart_rx_o
);
   localparam logic [11:0] STABLE_LAST = 12'(`RPC_OSC_STABLE_CYC - 1);

   rpc_regs_if rf();
   rpc_state_e state, next_state;
   logic [11:0] cnt, next_cnt;
   logic [3:0] ctl_q, gp_q, spi_q, gp_in;
   logic pd, tst, ext_prev, flt_prev, rst_d, flt_act, float_req, spd_req, drive_ok;
   logic [1:0] sel;
   logic next_rst_ind, next_core_rst, next_osc, next_cur, next_iso, next_irq;
   logic next_drv, next_rx;
   logic [1:0] next_hsel;
   logic [3:0] next_spi_out, next_spi_oe_n, next_spi_core, next_gp_out, next_gp_oe_n;

   // ----------------------------------------
   // Input synchronisers and register file
   // ----------------------------------------
   rpc_sync3 #(.W(4)) u_sync_ctl (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .d_i({host_select_line_b_i, host_select_line_a_i, test_mode_enable_in_i,
            reset_powerdown_in_i}),
      .q_o(ctl_q)
   );
   rpc_sync3 #(.W(8)) u_sync_io (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .d_i({spi_pin_in_i, gp_pin_in_i}),
      .q_o({spi_q, gp_q})
   );
   rpc_apb_regs u_regs (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o),
      .intr_o(intr_o),
      .rf(rf.regs)
   );

   assign pd = ctl_q[0];
   assign tst = ctl_q[1];
   assign sel = ctl_q[3:2];
   assign gp_in = (state == ST_PWRDN) ? 4'h0 : gp_q; // [RULE1]
   assign flt_act = !gp_in[`RPC_PIN_FLT] && !rf.gp_dir[`RPC_PIN_FLT];
   assign float_req = rf.ctrl[`RPC_CTRL_FLOAT_EN] && flt_act;
   assign spd_req = rf.ctrl[`RPC_CTRL_SPD_EN] && flt_act;
   assign rf.test_en = tst;
   assign rf.core_rst = core_reset_o;
   assign rf.test_in = (tst && state == ST_RUN) ? spi_q : 4'h0; // [RULE10]
   assign rf.status = {2'h0, gp_in, 2'h0, host_sel_o, state, tst, pd, 2'h0};
   // Controller events: external interrupt fall, float pin assertion, reset done
   assign rf.evt[`RPC_EVT_EXT] = rf.ctrl[`RPC_CTRL_EXT_EN] && ext_prev
      && !gp_in[`RPC_PIN_EXT] && state == ST_RUN; // [RULE7]
   assign rf.evt[`RPC_EVT_FLT] = flt_act && !flt_prev && state == ST_RUN;
   assign rf.evt[`RPC_EVT_RDY] = rst_d && state == ST_RUN;

   // ----------------------------------------
   // Power and reset sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = 12'h000;
      unique case (state)
         ST_RUN: begin
            if (pd) begin
               next_state = ST_PWRDN; // [RULE2]
            end else if (spd_req) begin
               next_state = ST_SOFTPD; // [RULE6]
            end
         end
         ST_PWRDN: begin
            if (!pd) begin
               next_state = ST_RSTWAIT;
            end
         end
         ST_RSTWAIT: begin
            if (pd) begin
               next_state = ST_PWRDN;
            end else if (cnt == STABLE_LAST) begin
               next_state = ST_RUN; // [RULE13]
            end else begin
               next_cnt = cnt + 12'h001;
            end
         end
         ST_SOFTPD: begin
            if (pd) begin
               next_state = ST_PWRDN; // [RULE2]
            end else if (!spd_req) begin
               next_state = ST_RUN;
            end
         end
      endcase
      next_hsel = (state == ST_RSTWAIT && next_state == ST_RUN) ? sel : host_sel_o; // [RULE12]
   end

   // ----------------------------------------
   // Pin outputs, computed from the next state
   // ----------------------------------------
   always_comb begin
      next_osc = next_state inside {ST_RUN, ST_RSTWAIT}; // [RULE1] [RULE6]
      next_cur = next_osc; // [RULE1]
      next_iso = next_state == ST_PWRDN; // [RULE1]
      next_core_rst = next_state inside {ST_PWRDN, ST_RSTWAIT}; // [RULE2]
      next_rst_ind = !next_core_rst; // [RULE3] [RULE13]
      next_irq = next_state == ST_RUN && rf.port7_irq; // [RULE4] [RULE14]
      drive_ok = next_state == ST_RUN && !float_req && !tst; // [RULE5] [RULE14]
      next_drv = drive_ok;
      next_spi_out = 4'h0;
      next_spi_oe_n = 4'hF;
      next_spi_core = (tst || next_state != ST_RUN) ? 4'h0 : spi_q;
      if (tst && next_state == ST_RUN) begin
         next_spi_out = rf.test_out; // [RULE10]
         next_spi_oe_n = ~rf.test_drv; // [RULE10]
      end else begin
         next_spi_out[`RPC_SPI_MISO] = spi_core_miso_i;
         next_spi_oe_n[`RPC_SPI_MISO] = !(drive_ok && host_sel_o == `RPC_HSEL_SPI); // [RULE5]
      end
      next_gp_out = 4'h0;
      next_gp_oe_n = 4'hF;
      next_rx = 1'b1;
      if (next_state != ST_PWRDN) begin
         next_gp_out = rf.gp_out; // [RULE7]
         next_gp_oe_n = ~rf.gp_dir;
         if (rf.ctrl[`RPC_CTRL_TX_SEL]) begin
            next_gp_out[`RPC_PIN_TX] = aux_uart_tx_i; // [RULE8]
            next_gp_oe_n[`RPC_PIN_TX] = 1'b0;
         end
         if (rf.ctrl[`RPC_CTRL_RX_SEL]) begin
            next_gp_oe_n[`RPC_PIN_RX] = 1'b1; // [RULE9]
            next_rx = gp_in[`RPC_PIN_RX];
         end
      end
   end

   // Register state and every output except the APB answer and intr_o
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state <= ST_RSTWAIT;
         cnt <= 12'h000;
         ext_prev <= 1'b1;
         flt_prev <= 1'b0;
         rst_d <= 1'b1;
         reset_indicator_out_o <= 1'b0;
         core_reset_o <= 1'b1;
         osc_enable_o <= 1'b1;
         current_src_en_o <= 1'b1;
         pad_isolate_o <= 1'b0;
         host_irq_o <= 1'b0;
         host_drive_en_o <= 1'b0;
         host_sel_o <= 2'h0;
         spi_pin_out_o <= 4'h0;
         spi_pin_oe_n_o <= 4'hF;
         spi_core_in_o <= 4'h0;
         gp_pin_out_o <= 4'h0;
         gp_pin_oe_n_o <= 4'hF;
         aux_uart_rx_o <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         ext_prev <= gp_in[`RPC_PIN_EXT];
         flt_prev <= flt_act;
         rst_d <= core_reset_o;
         reset_indicator_out_o <= next_rst_ind;
         core_reset_o <= next_core_rst;
         osc_enable_o <= next_osc;
         current_src_en_o <= next_cur;
         pad_isolate_o <= next_iso;
         host_irq_o <= next_irq;
         host_drive_en_o <= next_drv;
         host_sel_o <= next_hsel;
         spi_pin_out_o <= next_spi_out;
         spi_pin_oe_n_o <= next_spi_oe_n;
         spi_core_in_o <= next_spi_core;
         gp_pin_out_o <= next_gp_out;
         gp_pin_oe_n_o <= next_gp_oe_n;
         aux_uart_rx_o <= next_rx;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   property p_pd_off; // [RULE1]
      state == ST_PWRDN |-> !osc_enable_o && !current_src_en_o && pad_isolate_o;
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("power-down outputs wrong");

   property p_rise_reset; // [RULE2]
      state == ST_RUN && pd |=> state == ST_PWRDN && core_reset_o;
   endproperty
   a_rise_reset: assert property (p_rise_reset) else $error("reset phase not started");

   property p_ind_low; // [RULE3]
      state inside {ST_PWRDN, ST_RSTWAIT} |-> !reset_indicator_out_o && core_reset_o;
   endproperty
   a_ind_low: assert property (p_ind_low) else $error("indicator high in reset");

   property p_irq_follow; // [RULE4]
      (rf.port7_irq && state == ST_RUN)[*2] |-> host_irq_o;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("irq not following port 7");

   property p_float; // [RULE5]
      state == ST_RUN && float_req |=> spi_pin_oe_n_o[`RPC_SPI_MISO] && !host_drive_en_o;
   endproperty
   a_float: assert property (p_float) else $error("host outputs not floated");

   property p_softpd; // [RULE6]
      state == ST_SOFTPD |-> !core_reset_o && reset_indicator_out_o && !osc_enable_o;
   endproperty
   a_softpd: assert property (p_softpd) else $error("soft power-down reset or clocked");

   property p_ext_int; // [RULE7]
      state == ST_RUN && rf.ctrl[`RPC_CTRL_EXT_EN] && $fell(gp_in[`RPC_PIN_EXT])
         |-> rf.evt[`RPC_EVT_EXT];
   endproperty
   a_ext_int: assert property (p_ext_int) else $error("external interrupt lost");

   property p_tx_mux; // [RULE8]
      state == ST_RUN && !pd && !spd_req && rf.ctrl[`RPC_CTRL_TX_SEL]
         |=> gp_pin_out_o[`RPC_PIN_TX] == $past(aux_uart_tx_i) && !gp_pin_oe_n_o[`RPC_PIN_TX];
   endproperty
   a_tx_mux: assert property (p_tx_mux) else $error("serial transmit not routed");

   property p_rx_mux; // [RULE9]
      state == ST_RUN && !pd && !spd_req && rf.ctrl[`RPC_CTRL_RX_SEL]
         |=> aux_uart_rx_o == $past(gp_in[`RPC_PIN_RX]) && gp_pin_oe_n_o[`RPC_PIN_RX];
   endproperty
   a_rx_mux: assert property (p_rx_mux) else $error("serial receive not routed");

   property p_test_spi; // [RULE10]
      state == ST_RUN && tst && !pd && !spd_req |=> spi_pin_oe_n_o == ~$past(rf.test_drv);
   endproperty
   a_test_spi: assert property (p_test_spi) else $error("test drive not on spi pins");

   property p_test_block; // [RULE11]
      !tst [*2] |-> rf.test_drv == 4'h0 && rf.test_in == 4'h0;
   endproperty
   a_test_block: assert property (p_test_block) else $error("test access not blocked");

   property p_hsel; // [RULE12]
      $rose(reset_indicator_out_o) && $past(state) == ST_RSTWAIT |-> host_sel_o == $past(sel);
   endproperty
   a_hsel: assert property (p_hsel) else $error("host select not captured");

   property p_stable; // [RULE13]
      $rose(reset_indicator_out_o) |-> $past(cnt) == STABLE_LAST;
   endproperty
   a_stable: assert property (p_stable) else $error("reset released too early");

   property p_pd_quiet; // [RULE14]
      state == ST_PWRDN |-> !host_irq_o && !host_drive_en_o && spi_pin_oe_n_o == 4'hF;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("outputs active in power-down");

   c_pd_cycle: cover property (state == ST_PWRDN ##1 state == ST_RSTWAIT);
   c_ready: cover property (state == ST_RSTWAIT ##1 state == ST_RUN);
   c_softpd: cover property (state == ST_RUN ##1 state == ST_SOFTPD);
   c_test: cover property (tst && state == ST_RUN && rf.test_drv != 4'h0);
endmodule // rpc_pin_ctrl
`default_nettype wire

// ==== sim/rpc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpc_host_model
   import rpc_pkg::*;
(
   input wire logic pd_i,
   input wire logic float_n_i,
   input wire logic ext_i,
   input wire logic rx_i,
   input wire logic test_i,
   input wire logic [1:0] sel_i,
   input wire rpc_nib_t gp_pin_out_i,
   input wire rpc_nib_t gp_pin_oe_n_i,
   input wire rpc_nib_t spi_pin_out_i,
   input wire rpc_nib_t spi_pin_oe_n_i,
   output logic reset_powerdown_in_o,
   output logic test_mode_enable_in_o,
   output logic host_select_line_a_o,
   output logic host_select_line_b_o,
   output rpc_nib_t gp_pin_in_o,
   output rpc_nib_t spi_pin_in_o
);
   // -----------------------------------------
   // Host side of the pins
   // -----------------------------------------
   localparam rpc_nib_t SPI_LVL = 4'h5;
   rpc_nib_t lvl;

   // Host commands follow bench requests made just after an edge
   assign reset_powerdown_in_o = pd_i;
   assign test_mode_enable_in_o = test_i;
   assign host_select_line_a_o = sel_i[0];
   assign host_select_line_b_o = sel_i[1];
   // Float pin driven by host from float_n_i, low to float; tx pin pulled up
   assign lvl = {float_n_i, ext_i, rx_i, 1'b1};
   // Wire level: device wins while its enable is low
   assign gp_pin_in_o = (gp_pin_out_i & ~gp_pin_oe_n_i) | (lvl & gp_pin_oe_n_i);
   assign spi_pin_in_o = (spi_pin_out_i & ~spi_pin_oe_n_i) | (SPI_LVL & spi_pin_oe_n_i);
endmodule // rpc_host_model
`default_nettype wire

// ==== sim/reset_powerdown_pin_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"
module reset_powerdown_pin_control_bench
   import rpc_pkg::*;
;
   logic ref_clk_i, srst_i, psel_i, penable_i, pwrite_i, aux_uart_tx_i, spi_core_miso_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic pready_o, pslverr_o, intr_o, reset_indicator_out_o, core_reset_o, er;
   logic osc_enable_o, current_src_en_o, pad_isolate_o, host_irq_o, host_drive_en_o;
   logic aux_uart_rx_o, pd, flt_n, ext, rxl, ten;
   logic [1:0] sel, host_sel_o;
   wire reset_powerdown_in_i, test_mode_enable_in_i, host_select_line_a_i, host_select_line_b_i;
   wire [3:0] spi_pin_in_i, gp_pin_in_i;
   rpc_nib_t spi_pin_out_o, spi_pin_oe_n_o, spi_core_in_o, gp_pin_out_o, gp_pin_oe_n_o;
   int num_errors, n_compared, cyc;

   rpc_pin_ctrl i_rpc_pin_ctrl (.ref_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .intr_o,
      .reset_powerdown_in_i, .test_mode_enable_in_i, .host_select_line_a_i,
      .host_select_line_b_i, .reset_indicator_out_o, .core_reset_o, .osc_enable_o,
      .current_src_en_o, .pad_isolate_o, .host_irq_o, .host_drive_en_o, .host_sel_o,
      .spi_pin_in_i, .spi_pin_out_o, .spi_pin_oe_n_o, .spi_core_in_o, .spi_core_miso_i,
      .gp_pin_in_i, .gp_pin_out_o, .gp_pin_oe_n_o, .aux_uart_tx_i, .aux_uart_rx_o);
   rpc_host_model i_rpc_host_model (.pd_i(pd), .float_n_i(flt_n), .ext_i(ext), .rx_i(rxl),
      .test_i(ten), .sel_i(sel), .gp_pin_out_i(gp_pin_out_o), .gp_pin_oe_n_i(gp_pin_oe_n_o),
      .spi_pin_out_i(spi_pin_out_o), .spi_pin_oe_n_i(spi_pin_oe_n_o),
      .reset_powerdown_in_o(reset_powerdown_in_i), .test_mode_enable_in_o(test_mode_enable_in_i),
      .host_select_line_a_o(host_select_line_a_i), .host_select_line_b_o(host_select_line_b_i),
      .gp_pin_in_o(gp_pin_in_i), .spi_pin_in_o(spi_pin_in_i));

   // -----------------------------------------
   // Tasks
   // -----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      @(posedge ref_clk_i);
      while (pready_o !== 1'b1 && n < 50) begin
         @(posedge ref_clk_i);
         n++;
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      chk(32'(n < 50), 32'h1, "bus answer");
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, msg);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // Counts cycles until the reset indicator rises
   task automatic wait_ind();
      cyc = 0;
      while (reset_indicator_out_o !== 1'b1 && cyc < 400) begin
         @(posedge ref_clk_i);
         cyc++;
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // -----------------------------------------
   // Clock, watchdog and tests
   // -----------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      tick(20000);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      {srst_i, psel_i, penable_i, pwrite_i, aux_uart_tx_i, spi_core_miso_i} = 6'b10_0000;
      {paddr_i, pwdata_i} = '0;
      {pd, flt_n, ext, rxl, ten, sel} = 7'b0111_010;
      tick(4);
      chk(32'({reset_indicator_out_o, core_reset_o}), 32'h1, "in reset");
      srst_i <= 1'b0;
      wait_ind();
      chk(32'(cyc >= `RPC_OSC_STABLE_CYC && cyc < 400), 32'h1, "stable wait");
      chk(32'({core_reset_o, osc_enable_o, host_sel_o}), 32'h6, "run, select");
      apb(1'b1, `RPC_ADDR_INT_STAT, 32'h0000_0007);
      apb(1'b1, `RPC_ADDR_PORT7, 32'h0000_0001);
      tick(2);
      chk(32'(host_irq_o), 32'h1, "irq high");
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({rd[30:0], er}, 32'h1, "unmapped");
      apb(1'b1, `RPC_ADDR_GP_OUT, 32'h0000_0004);
      apb(1'b1, `RPC_ADDR_GP_DIR, 32'h0000_0004);
      tick(2);
      chk(32'({gp_pin_oe_n_o[2], gp_pin_out_o[2]}), 32'h1, "ext pin as output");
      apb(1'b1, `RPC_ADDR_GP_DIR, 32'h0000_0000);
      apb(1'b1, `RPC_ADDR_CTRL, 32'h0000_0010);
      tick(8);
      ext <= 1'b0;
      tick(10);
      rdc(`RPC_ADDR_INT_STAT, 32'h0000_0001, "ext event");
      apb(1'b1, `RPC_ADDR_INT_STAT, 32'h0000_0001);
      ext <= 1'b1;
      apb(1'b1, `RPC_ADDR_CTRL, 32'h0000_000C);
      aux_uart_tx_i <= 1'b1;
      rxl <= 1'b0;
      tick(8);
      chk(32'({gp_pin_oe_n_o[0], gp_pin_out_o[0]}), 32'h1, "tx routed");
      chk(32'(aux_uart_rx_o), 32'h0, "rx routed");
      apb(1'b1, `RPC_ADDR_CTRL, 32'h0000_0001);
      tick(3);
      chk(32'({gp_pin_oe_n_o[0], aux_uart_rx_o}), 32'h3, "aux as gpio");
      flt_n <= 1'b0;
      tick(8);
      chk(32'(host_drive_en_o), 32'h0, "float");
      flt_n <= 1'b1;
      apb(1'b1, `RPC_ADDR_CTRL, 32'h0000_0002);
      tick(8);
      chk(32'({host_drive_en_o, spi_core_in_o}), 32'h11, "unfloat");
      flt_n <= 1'b0;
      tick(8);
      chk(32'({osc_enable_o, reset_indicator_out_o}), 32'h1, "soft pd");
      flt_n <= 1'b1;
      tick(8);
      rdc(`RPC_ADDR_PORT7, 32'h0000_0001, "state kept");
      rdc(`RPC_ADDR_INT_STAT, 32'h0000_0002, "float event");
      ten <= 1'b1;
      tick(8);
      apb(1'b1, `RPC_ADDR_TEST, 32'h0000_00FA);
      tick(8);
      chk(32'({spi_pin_oe_n_o, spi_pin_out_o, host_drive_en_o}), 32'h0000_0014, "tst");
      rdc(`RPC_ADDR_TEST, 32'h0000_0AFA, "test pins");
      ten <= 1'b0;
      tick(8);
      rdc(`RPC_ADDR_TEST, 32'h0000_0000, "test cleared");
      chk(32'(spi_pin_oe_n_o), 32'hB, "test blocked");
      pd <= 1'b1;
      tick(8);
      chk(32'({reset_indicator_out_o, core_reset_o, osc_enable_o, current_src_en_o}),
          32'h4, "hard pd");
      chk(32'({pad_isolate_o, host_irq_o, host_drive_en_o}), 32'h4, "quiet");
      pd <= 1'b0;
      wait_ind();
      chk(32'(cyc >= `RPC_OSC_STABLE_CYC && cyc < 400), 32'h1, "pd wait");
      rdc(`RPC_ADDR_PORT7, 32'h0000_0000, "reset done");
      rdc(`RPC_ADDR_INT_STAT, 32'h0000_0004, "ready event");
      rdc(`RPC_ADDR_STATUS, 32'h0000_3480, "status");
      apb(1'b1, `RPC_ADDR_INT_MASK, 32'h0000_0004);
      tick(2);
      chk(32'(intr_o), 32'h1, "unmasked");
      apb(1'b1, `RPC_ADDR_INT_STAT, 32'h0000_0004);
      tick(2);
      chk(32'(intr_o), 32'h0, "cleared");
      tally_and_finish();
   end
endmodule // reset_powerdown_pin_control_bench
`default_nettype wire
